// ---- verilog/lhpm_regs.svh ----
/*
 * register indices, field positions, reset values and timing for the
 * left headphone mix register bank.
 * assumes: included by bare name; byte address on the bus is four times the index.
 */
`ifndef LHPM_REGS_SVH
`define LHPM_REGS_SVH

// register indices
`define LHPM_IDX_LPRE_HPL   8'h2e
`define LHPM_IDX_LDAC_HPL   8'h2f
`define LHPM_IDX_RSVD_A     8'h30
`define LHPM_IDX_RPRE_HPL   8'h31
`define LHPM_IDX_RDAC_HPL   8'h32
`define LHPM_IDX_LVL        8'h33
`define LHPM_IDX_RSVD_B     8'h34
`define LHPM_IDX_LPRE_COMP  8'h35
`define LHPM_IDX_LDAC_COMP  8'h36
`define LHPM_IDX_RSVD_C     8'h37
`define LHPM_IDX_RPRE_COMP  8'h38

// bus geometry
`define LHPM_ADDR_W         10
`define LHPM_IDX_MSB        9
`define LHPM_IDX_LSB        2
`define LHPM_ALIGN_MSB      1
`define LHPM_ALIGN_OK       2'h0
`define LHPM_BE_LANE0       0
`define LHPM_RD_PAD         24'h000000

// mix register fields
`define LHPM_ROUTE_BIT      7
`define LHPM_ATTEN_MSB      6
`define LHPM_ATTEN_W        7
`define LHPM_MIX_RST        8'h00
`define LHPM_MUTE_CODE      7'h76
`define LHPM_NPATH          7
`define LHPM_NSTAGED        4

// level register fields
`define LHPM_GAIN_MSB       7
`define LHPM_GAIN_LSB       4
`define LHPM_UNMUTE_BIT     3
`define LHPM_PDHIZ_BIT      2
`define LHPM_PEND_BIT       1
`define LHPM_PWR_BIT        0
`define LHPM_LVL_RST        8'h06
`define LHPM_GAIN_RST       4'h0

// gain settle time
`define LHPM_CLK_MHZ        200
`define LHPM_SETTLE_NS      1000
`define LHPM_CNT_W          8

`endif

// ---- verilog/lhpm_pkg.sv ----
/*
 * types for the left headphone mix register bank.
 * assumes: compiled before the module that uses it.
 */
package lhpm_pkg;

    // gain settle tracker, one-hot
    typedef enum logic [1:0] {
        LHPM_IDLE = 2'b01,
        LHPM_RAMP = 2'b10
    } lhpm_ramp_t;

endpackage : lhpm_pkg

// ---- verilog/lhpm_top.sv ----
/*
 * left headphone mix register bank: seven routing/attenuation registers,
 * the left headphone driver level/mute/power register and a gain-pending tracker,
 * reached over an avalon-mm slave with waitrequest.
 * assumes: one clock, synchronous active-low reset, master holds requests until
 * waitrequest is seen low.
 */
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "lhpm_regs.svh"

// Summary of operation
// - left_pre_to_left_hp_mix: route and attenuation
// - attenuation code steps; codes 118+ mute
// - left_dac_to_left_hp_mix: route and attenuation
// - right_pre_to_left_hp_mix: route and attenuation
// - right_dac_to_left_hp_mix: route and attenuation
// - left_pre_to_left_comp_mix: route and attenuation
// - left_dac_to_left_comp_mix: route and attenuation
// - right_pre_to_left_comp_mix: route and attenuation
// - level bits 7-4: output gain 0-9 dB
// - level bit 3 unmutes driver
// - level bit 2: powered-down high impedance
// - level bit 1 reads gain pending
// - level bit 0 powers driver up
module lhpm_top (
    input  wire logic                           core_clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           ce_i,
    input  wire logic [`LHPM_ADDR_W-1:0]        avs_address_i,
    input  wire logic                           avs_read_i,
    input  wire logic                           avs_write_i,
    input  wire logic [31:0]                    avs_writedata_i,
    input  wire logic [3:0]                     avs_byteenable_i,
    output logic      [31:0]                    avs_readdata_o,
    output logic                                avs_waitrequest_o,
    output logic      [`LHPM_NPATH-1:0]         route_o,
    output logic      [`LHPM_NPATH*`LHPM_ATTEN_W-1:0] atten_o,
    output logic      [`LHPM_NPATH-1:0]         path_mute_o,
    output logic      [3:0]                     hp_gain_o,
    output logic                                hp_unmute_o,
    output logic                                hp_pd_hiz_o,
    output logic                                hp_power_o,
    output logic                                hp_pending_o
);

    ////////////////////////////////////////////////////////////////////////////
    // constants

    localparam logic [7:0] MIX_IDX [`LHPM_NPATH] = '{
        `LHPM_IDX_LPRE_HPL, `LHPM_IDX_LDAC_HPL, `LHPM_IDX_RPRE_HPL, `LHPM_IDX_RDAC_HPL,
        `LHPM_IDX_LPRE_COMP, `LHPM_IDX_LDAC_COMP, `LHPM_IDX_RPRE_COMP
    };

    // least time, so round up
    localparam logic [`LHPM_CNT_W-1:0] SETTLE_CYC =
        `LHPM_CNT_W'((`LHPM_SETTLE_NS * `LHPM_CLK_MHZ + 999) / 1000);
    localparam logic [`LHPM_CNT_W-1:0] SETTLE_LAST = `LHPM_CNT_W'(1);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic                           wait_r;
    logic [31:0]                    rdata_r;
    logic [7:0]                     mix_r [`LHPM_NPATH];
    logic [3:0]                     gain_r;
    logic                           unmute_r;
    logic                           pdhiz_r;
    logic                           pwr_r;
    logic [3:0]                     gain_app_r;
    logic                           pend_r;
    logic [`LHPM_CNT_W-1:0]         cnt_r;
    lhpm_pkg::lhpm_ramp_t           state_r;
    logic [`LHPM_NPATH-1:0]         route_r;
    logic [`LHPM_NPATH*`LHPM_ATTEN_W-1:0] atten_r;
    logic [`LHPM_NPATH-1:0]         pmute_r;

    logic [7:0]                     idx;
    logic                           aligned;
    logic                           wr_acc;
    logic                           rd_cap;
    logic [`LHPM_NPATH-1:0]         mix_wr;
    logic                           lvl_wr;
    logic                           hpl_wr;
    logic                           done;
    logic [7:0]                     rd8_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign idx     = avs_address_i[`LHPM_IDX_MSB:`LHPM_IDX_LSB];
    assign aligned = (avs_address_i[`LHPM_ALIGN_MSB:0] == `LHPM_ALIGN_OK);
    // a write lands only at the edge where waitrequest is seen low
    assign wr_acc  = ce_i & avs_write_i & ~wait_r & aligned & avs_byteenable_i[`LHPM_BE_LANE0];
    assign rd_cap  = ce_i & avs_read_i & wait_r;
    assign lvl_wr  = wr_acc & (idx == `LHPM_IDX_LVL);
    assign hpl_wr  = lvl_wr | (|mix_wr[`LHPM_NSTAGED-1:0]);

    // one wait state per access: rdata is captured while waitrequest is high
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wait_r <= 1'b1;
        end else if (ce_i) begin
            wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
        end
    end

    always_comb begin
        rd8_nxt = `LHPM_MIX_RST;
        if (aligned) begin
            for (int k = 0; k < `LHPM_NPATH; k++) begin
                if (idx == MIX_IDX[k]) begin
                    rd8_nxt = mix_r[k];
                end
            end
            if (idx == `LHPM_IDX_LVL) begin
                rd8_nxt = {gain_r, unmute_r, pdhiz_r, pend_r, pwr_r};
            end
        end
    end

    // reserved and unmapped words read zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= {`LHPM_RD_PAD, `LHPM_MIX_RST};
        end else if (rd_cap) begin
            rdata_r <= {`LHPM_RD_PAD, rd8_nxt};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routing and attenuation registers

    genvar gi;
    generate
        for (gi = 0; gi < `LHPM_NPATH; gi++) begin : g_path
            localparam bit STAGED = (gi < `LHPM_NSTAGED);
            logic                     load;
            logic [`LHPM_ATTEN_W-1:0] src;

            assign mix_wr[gi] = wr_acc & aligned & (idx == MIX_IDX[gi]);
            // headphone paths wait for the settle tracker, complementary ones apply at once
            assign load = STAGED ? done : mix_wr[gi];
            assign src  = STAGED ? mix_r[gi][`LHPM_ATTEN_MSB:0] : avs_writedata_i[`LHPM_ATTEN_MSB:0];

            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    mix_r[gi]   <= `LHPM_MIX_RST;
                    route_r[gi] <= 1'b0;
                end else if (mix_wr[gi]) begin
                    mix_r[gi]   <= avs_writedata_i[7:0];
                    route_r[gi] <= avs_writedata_i[`LHPM_ROUTE_BIT];
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    atten_r[gi*`LHPM_ATTEN_W +: `LHPM_ATTEN_W] <= `LHPM_ATTEN_W'(`LHPM_MIX_RST);
                    pmute_r[gi] <= 1'b0;
                end else if (ce_i && load) begin
                    atten_r[gi*`LHPM_ATTEN_W +: `LHPM_ATTEN_W] <= src;
                    pmute_r[gi] <= (src >= `LHPM_MUTE_CODE);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // level, mute and power register

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            gain_r   <= `LHPM_GAIN_RST;
            unmute_r <= 1'(`LHPM_LVL_RST >> `LHPM_UNMUTE_BIT);
            pdhiz_r  <= 1'(`LHPM_LVL_RST >> `LHPM_PDHIZ_BIT);
            pwr_r    <= 1'(`LHPM_LVL_RST >> `LHPM_PWR_BIT);
        end else if (lvl_wr) begin
            // no clamp: software keeps to codes 0-9
            gain_r   <= avs_writedata_i[`LHPM_GAIN_MSB:`LHPM_GAIN_LSB];
            unmute_r <= avs_writedata_i[`LHPM_UNMUTE_BIT];
            pdhiz_r  <= avs_writedata_i[`LHPM_PDHIZ_BIT];
            pwr_r    <= avs_writedata_i[`LHPM_PWR_BIT];
        end
    end

    // gain reaches the driver once settled
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            gain_app_r <= `LHPM_GAIN_RST;
        end else if (ce_i && done) begin
            gain_app_r <= gain_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gain settle tracker

    // a write in the finishing cycle restarts the wait, so no update is lost
    assign done = (state_r == lhpm_pkg::LHPM_RAMP) && (cnt_r == SETTLE_LAST) && !hpl_wr;

    // pending set by a level or headphone-path write, cleared when applied
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_r <= lhpm_pkg::LHPM_RAMP;
            cnt_r   <= SETTLE_CYC;
            pend_r  <= 1'b1;
        end else if (ce_i) begin
            case (state_r)
                lhpm_pkg::LHPM_IDLE: begin
                    if (hpl_wr) begin
                        state_r <= lhpm_pkg::LHPM_RAMP;
                        cnt_r   <= SETTLE_CYC;
                        pend_r  <= 1'b1;
                    end
                end
                lhpm_pkg::LHPM_RAMP: begin
                    if (hpl_wr) begin
                        cnt_r  <= SETTLE_CYC;
                        pend_r <= 1'b1;
                    end else if (done) begin
                        state_r <= lhpm_pkg::LHPM_IDLE;
                        pend_r  <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r - SETTLE_LAST;
                    end
                end
                default: begin
                    state_r <= lhpm_pkg::LHPM_IDLE;
                    pend_r  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o    = rdata_r;
    assign route_o           = route_r;
    assign atten_o           = atten_r;
    assign path_mute_o       = pmute_r;
    assign hp_gain_o         = gain_app_r;
    assign hp_unmute_o       = unmute_r;
    assign hp_pd_hiz_o       = pdhiz_r;
    assign hp_power_o        = pwr_r;
    assign hp_pending_o      = pend_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_lpre_hpl_route: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        mix_wr[0] |=> route_o[0] == $past(avs_writedata_i[`LHPM_ROUTE_BIT])
                      && hp_pending_o)
        else $error("left preamp route not stored");

    chk_mute_code_map: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (ce_i && mix_wr[4]) |=> path_mute_o[4] == ($past(avs_writedata_i[`LHPM_ATTEN_MSB:0]) >= `LHPM_MUTE_CODE))
        else $error("path mute does not follow code");

    chk_ldac_hpl_stage: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        mix_wr[1] |=> route_o[1] == $past(avs_writedata_i[`LHPM_ROUTE_BIT])
                      ##0 (atten_o[13:7] == $past(atten_o[13:7])))
        else $error("left converter path applied before settle");

    chk_rpre_hpl_route: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        mix_wr[2] |=> route_o[2] == $past(avs_writedata_i[`LHPM_ROUTE_BIT]))
        else $error("right preamp route not stored");

    chk_rdac_hpl_apply: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (ce_i && done) |=> atten_o[27:21] == $past(mix_r[3][`LHPM_ATTEN_MSB:0]))
        else $error("right converter code not applied at settle");

    chk_lpre_comp_now: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        mix_wr[4] |=> atten_o[34:28] == $past(avs_writedata_i[`LHPM_ATTEN_MSB:0])
                      && route_o[4] == $past(avs_writedata_i[`LHPM_ROUTE_BIT]))
        else $error("complementary left preamp not applied");

    chk_ldac_comp_now: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        mix_wr[5] |=> atten_o[41:35] == $past(avs_writedata_i[`LHPM_ATTEN_MSB:0]))
        else $error("complementary left converter not applied");

    chk_rpre_comp_now: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        mix_wr[6] |=> route_o[6] == $past(avs_writedata_i[`LHPM_ROUTE_BIT])
                      && atten_o[48:42] == $past(avs_writedata_i[`LHPM_ATTEN_MSB:0]))
        else $error("complementary right preamp not stored");

    chk_gain_settled: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !hp_pending_o |-> hp_gain_o == gain_r)
        else $error("driver gain differs from programmed gain when settled");

    chk_unmute_store: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        lvl_wr |=> hp_unmute_o == $past(avs_writedata_i[`LHPM_UNMUTE_BIT]))
        else $error("unmute bit not stored");

    chk_pdhiz_store: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        lvl_wr |=> hp_pd_hiz_o == $past(avs_writedata_i[`LHPM_PDHIZ_BIT]))
        else $error("power-down drive bit not stored");

    chk_pend_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        hpl_wr |=> hp_pending_o [*8])
        else $error("pending dropped too early");

    chk_power_store: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        lvl_wr |=> hp_power_o == $past(avs_writedata_i[`LHPM_PWR_BIT]))
        else $error("power bit not stored");

    chk_pend_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(hp_pending_o) |-> $past(done) && !$past(hpl_wr))
        else $error("pending cleared without settle");

    chk_pend_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (hpl_wr && ce_i) ##1 (!hpl_wr && ce_i) [*8] |-> hp_pending_o)
        else $error("pending lost during settle");

endmodule // lhpm_top

`default_nettype wire

// ---- test/lhpm_top_test.sv ----
/*
 * self-checking bench for the left headphone mix register bank.
 * assumes: lhpm_regs.svh on the include path, avalon-mm slave with one wait cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lhpm_regs.svh"

module lhpm_top_test;
    localparam int SETTLE = `LHPM_SETTLE_NS * `LHPM_CLK_MHZ / 1000;
    localparam int CEIL   = 30000;
    logic        core_clk_i, rst_n_i, ce_i, avs_read_i, avs_write_i;
    logic [9:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, lfsr;
    logic [3:0]  avs_byteenable_i, hp_gain_o, gain_app;
    logic        avs_waitrequest_o, hp_unmute_o, hp_pd_hiz_o, hp_power_o, hp_pending_o;
    logic [6:0]  route_o, path_mute_o;
    logic [48:0] atten_o;
    logic [7:0]  mix_m [7];
    logic [6:0]  app_m [7];
    logic [7:0]  idx_t [7] = '{8'h2e, 8'h2f, 8'h31, 8'h32, 8'h35, 8'h36, 8'h38};
    logic [7:0]  lvl_m, e_rd;
    logic [7:0]  exp_q [$];
    int          fail_count, samples_checked, cyc, n;

    lhpm_top lhpm_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .route_o(route_o), .atten_o(atten_o), .path_mute_o(path_mute_o), .hp_gain_o(hp_gain_o),
        .hp_unmute_o(hp_unmute_o), .hp_pd_hiz_o(hp_pd_hiz_o), .hp_power_o(hp_power_o),
        .hp_pending_o(hp_pending_o));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check_val(input string nm, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // hang guard
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == CEIL) begin
            fail_count++;
            close_out();
        end
    end

    // read monitor: oldest note against data seen in the answer cycle
    always @(posedge core_clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            if (exp_q.size() == 0) check_val("unexpected read", 64'h0, 64'h1);
            else begin
                e_rd = exp_q.pop_front();
                check_val("readdata", {24'h0, e_rd}, avs_readdata_o);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus_req(input logic [9:0] a, input logic rd, input logic [7:0] d, input logic [3:0] be);
        int k;
        k = 0;
        lfsr = lfsr_next(lfsr);
        avs_address_i    <= a;
        avs_read_i       <= rd;
        avs_write_i      <= !rd;
        avs_writedata_i  <= {lfsr[23:0], d};
        avs_byteenable_i <= be;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0);
        check_val("wait cycles", 64'd2, k);
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        bus_req({i, 2'b00}, 1'b0, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        exp_q.push_back(e);
        bus_req({i, 2'b00}, 1'b1, 8'h00, 4'hf);
    endtask

    task automatic wr_mix(input int k, input logic [7:0] d);
        wr(idx_t[k], d);
        mix_m[k] = d;
        if (k >= 4) app_m[k] = d[6:0];
    endtask

    task automatic apply_all();
        for (int k = 0; k < 4; k++) app_m[k] = mix_m[k][6:0];
        gain_app = lvl_m[7:4];
    endtask

    task automatic check_paths();
        for (int k = 0; k < 7; k++) begin
            check_val("route", {63'h0, mix_m[k][7]}, {63'h0, route_o[k]});
            check_val("atten", {57'h0, app_m[k]}, {57'h0, atten_o[7*k+:7]});
            check_val("path mute", {63'h0, app_m[k] >= 7'd118}, {63'h0, path_mute_o[k]});
        end
    endtask

    task automatic check_lvl(input logic pend);
        check_val("gain", {60'h0, gain_app}, {60'h0, hp_gain_o});
        check_val("unmute", {63'h0, lvl_m[3]}, {63'h0, hp_unmute_o});
        check_val("pd hiz", {63'h0, lvl_m[2]}, {63'h0, hp_pd_hiz_o});
        check_val("power", {63'h0, lvl_m[0]}, {63'h0, hp_power_o});
        check_val("pending", {63'h0, pend}, {63'h0, hp_pending_o});
    endtask

    task automatic count_settle(output int c);
        c = 0;
        do begin
            @(posedge core_clk_i);
            c++;
        end while (hp_pending_o !== 1'b0 && c < 400);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        avs_address_i = 10'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'h0;
        lfsr = 32'h6b8f;
        fail_count = 0;
        samples_checked = 0;
        cyc = 0;
        for (int k = 0; k < 7; k++) begin
            mix_m[k] = 8'h00;
            app_m[k] = 7'h00;
        end
        lvl_m = 8'h04;
        gain_app = 4'h0;
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        check_paths();
        check_lvl(1'b1);
        for (int k = 0; k < 7; k++) rd(idx_t[k], 8'h00);
        rd(8'h30, 8'h00);
        rd(8'h34, 8'h00);
        rd(8'h37, 8'h00);
        rd(8'h33, 8'h06);
        count_settle(n);
        check_lvl(1'b0);
        $display("test reset done");

        // routes and complementary paths land at once, hp paths wait for settle
        for (int k = 0; k < 7; k++) begin
            lfsr = lfsr_next(lfsr);
            wr_mix(k, lfsr[7:0]);
        end
        wr_mix(0, 8'hf6);
        wr_mix(1, 8'h75);
        wr_mix(4, 8'h7f);
        check_paths();
        check_lvl(1'b1);
        rd(8'h33, 8'h06);
        count_settle(n);
        apply_all();
        check_paths();
        for (int k = 0; k < 7; k++) rd(idx_t[k], mix_m[k]);
        $display("test mix done");

        // legal codes only: every gain code 0-9, random flags, status bit written
        for (int g = 0; g < 10; g++) begin
            lfsr = lfsr_next(lfsr);
            lvl_m = {g[3:0], lfsr[3:2], 1'b0, lfsr[0]};
            wr(8'h33, {g[3:0], lfsr[3:0]});
            check_lvl(1'b1);
            count_settle(n);
            check_val("settle cycles", SETTLE, n);
            apply_all();
            check_lvl(1'b0);
            rd(8'h33, lvl_m);
        end
        $display("test level done");

        // a second write restarts the wait; a clock-enable gap freezes it
        lfsr = lfsr_next(lfsr);
        wr_mix(2, lfsr[7:0]);
        repeat (100) @(posedge core_clk_i);
        wr_mix(3, lfsr[15:8]);
        ce_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        check_lvl(1'b1);
        ce_i <= 1'b1;
        count_settle(n);
        check_val("restart cycles", SETTLE, n);
        apply_all();
        check_paths();
        $display("test restart done");

        // reserved unwritten; refused accesses change nothing
        wr(8'h10, 8'hff);
        wr(8'h20, 8'hff);
        wr(8'hf0, 8'hff);
        bus_req({8'h2e, 2'b01}, 1'b0, 8'hff, 4'h1);
        bus_req({8'h2f, 2'b00}, 1'b0, 8'hff, 4'he);
        rd(8'h30, 8'h00);
        rd(8'h34, 8'h00);
        rd(8'h37, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h2e, mix_m[0]);
        rd(8'h2f, mix_m[1]);
        exp_q.push_back(8'h00);
        bus_req({8'h2e, 2'b10}, 1'b1, 8'h00, 4'hf);
        check_paths();
        $display("test refused done");
        repeat (3) @(posedge core_clk_i);
        check_val("read notes left", 64'h0, exp_q.size());
        close_out();
    end
endmodule // lhpm_top_test
`default_nettype wire
